// file: rtl/cmd_pkg.sv
// package: frame layout, opcodes, status codes and constants of the command interpreter
package cmd_pkg;
  localparam int unsigned FRAME_BYTES   = 9;
  localparam logic [7:0]  OP_MOVE_POS   = 8'h04;
  localparam logic [7:0]  OP_DEF_VECTOR = 8'h25;
  localparam logic [7:0]  OP_RET_HANDLER = 8'h26;
  localparam logic [7:0]  OP_CUSTOM_LO  = 8'h40;
  localparam logic [7:0]  OP_CUSTOM_HI  = 8'h47;
  localparam logic [7:0]  OP_REACH_REQ  = 8'h8a;
  localparam logic [7:0]  ST_OK         = 8'h64;
  localparam logic [7:0]  ST_REACHED    = 8'h80;
  localparam logic [7:0]  ST_BAD_CMD    = 8'h02;
  localparam logic [7:0]  REPLY_ADDR    = 8'h02;
  localparam logic [7:0]  MODULE_ADDR   = 8'h01;
  localparam logic [7:0]  TYPE_ONCE     = 8'h00;
  localparam logic [7:0]  TYPE_EVERY    = 8'h01;
  localparam int unsigned VEC_AW        = 8;
  localparam int unsigned PROG_AW       = 16;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  opcode;
    logic [7:0]  ctype;
    logic [7:0]  bank;
    logic [31:0] value;
  } cmd_frame_s;

  typedef struct packed {
    logic [7:0]  host;
    logic [7:0]  module_id;
    logic [7:0]  status;
    logic [7:0]  opcode;
    logic [31:0] value;
  } reply_frame_s;

  // context saved when a handler is entered
  typedef struct packed {
    logic [31:0]        accu;
    logic [31:0]        xreg;
    logic [7:0]         flags;
    logic [PROG_AW-1:0] pc;
  } context_s;
endpackage : cmd_pkg

// file: rtl/vector_return_and_reach_event_cmds.sv
// command interpreter: vector definition, handler return, custom opcodes, target-reached event
`timescale 1ns/1ps
`default_nettype none
module vector_return_and_reach_event_cmds (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset,
  // command frame in, checksum is the ninth byte
  input  wire logic                      cmd_valid,
  input  wire cmd_pkg::cmd_frame_s       cmd,
  input  wire logic [7:0]                cmd_sum,
  input  wire logic                      direct_mode,
  // program context at handler entry
  input  wire logic                      irq_enter,
  input  wire cmd_pkg::context_s         live_ctx,
  input  wire logic [cmd_pkg::VEC_AW-1:0] vec_rd_num,
  // motor state, from logic on the same clock
  input  wire logic [31:0]               actual_pos,
  input  wire logic [31:0]               target_pos,
  // custom extension value from user logic
  input  wire logic [31:0]               custom_value,
  // reply out
  output var  logic                      reply_valid,
  output var  cmd_pkg::reply_frame_s     reply,
  output var  logic [7:0]                reply_sum,
  // program flow effects
  output var  logic                      ctx_restore,
  output var  cmd_pkg::context_s         restored_ctx,
  output var  logic                      in_handler,
  output var  logic [cmd_pkg::PROG_AW-1:0] vec_rd_addr,
  output var  logic                      custom_strobe,
  output var  cmd_pkg::cmd_frame_s       custom_cmd
);
  // ==========================================================
  // byte sums, one adder for each of the eight bytes ahead of the checksum, for commands and replies
  localparam int unsigned SUM_BYTES = cmd_pkg::FRAME_BYTES - 1;
  logic [8*SUM_BYTES-1:0] cmd_bytes;
  logic [8*SUM_BYTES-1:0] reply_bytes;
  logic [7:0]             cmd_part   [SUM_BYTES+1];
  logic [7:0]             reply_part [SUM_BYTES+1];
  assign cmd_bytes     = cmd;
  assign reply_bytes   = reply;
  assign cmd_part[0]   = 8'h00;
  assign reply_part[0] = 8'h00;
  for (genvar b = 0; b < SUM_BYTES; b++) begin : g_sum
    // the carry out of every byte is dropped, so the sum wraps modulo 256
    assign cmd_part[b+1]   = cmd_part[b] + cmd_bytes[8*b +: 8];
    assign reply_part[b+1] = reply_part[b] + reply_bytes[8*b +: 8];
  end

  // ==========================================================
  // frame check
  logic [7:0] calc_sum;
  logic       frame_ok;
  assign calc_sum = cmd_part[SUM_BYTES];
  // a frame for another module address is not ours, same as a bad sum
  assign frame_ok = cmd_valid && (calc_sum == cmd_sum)
                    && (cmd.addr == cmd_pkg::MODULE_ADDR);

  logic is_vec, is_ret, is_custom, is_reach, is_move;
  assign is_vec    = frame_ok && cmd.opcode == cmd_pkg::OP_DEF_VECTOR;
  assign is_ret    = frame_ok && cmd.opcode == cmd_pkg::OP_RET_HANDLER;
  assign is_custom = frame_ok && cmd.opcode >= cmd_pkg::OP_CUSTOM_LO
                     && cmd.opcode <= cmd_pkg::OP_CUSTOM_HI;
  assign is_reach  = frame_ok && cmd.opcode == cmd_pkg::OP_REACH_REQ;
  assign is_move   = frame_ok && cmd.opcode == cmd_pkg::OP_MOVE_POS;

  // ==========================================================
  // vector table
  vector_table #(
    .AW (cmd_pkg::VEC_AW),
    .DW (cmd_pkg::PROG_AW)
  ) u_vec (
    .mclk    (mclk),
    .wr_en   (is_vec && !direct_mode),
    .wr_addr (cmd.ctype),
    .wr_data (cmd.value[cmd_pkg::PROG_AW-1:0]),
    .rd_addr (vec_rd_num),
    .rd_data (vec_rd_addr)
  );

  // ==========================================================
  // saved context and return
  cmd_pkg::context_s saved_ctx;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      saved_ctx <= '0;
      in_handler <= 1'b0;
    end else if (irq_enter && !in_handler) begin
      saved_ctx <= live_ctx;
      in_handler <= 1'b1;
    end else if (is_ret && !direct_mode) begin
      in_handler <= 1'b0;
    end
  end

  // handlers do not nest; a stray return outside a handler gives no restore pulse
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctx_restore <= 1'b0;
      restored_ctx <= '0;
    end else begin
      ctx_restore <= is_ret && !direct_mode && in_handler;
      restored_ctx <= saved_ctx;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      custom_strobe <= 1'b0;
      custom_cmd <= '0;
    end else begin
      custom_strobe <= is_custom;
      custom_cmd <= cmd;
    end
  end

  // ==========================================================
  // target-reached arming
  logic       armed, every_move, tracking;
  logic [7:0] mask;
  logic       reached;
  assign reached = tracking && (actual_pos == target_pos);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      armed <= 1'b0;
      every_move <= 1'b0;
      mask <= '0;
    end else if (is_reach) begin
      armed <= 1'b1;
      every_move <= (cmd.ctype == cmd_pkg::TYPE_EVERY);
      mask <= cmd.value[7:0];
    end else if (is_move && armed && !every_move) begin
      armed <= 1'b0;
    end
  end

  // one reply per move: tracking ends when reached or replaced by the next move
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tracking <= 1'b0;
    end else if (is_move) begin
      tracking <= armed;
    end else if (reached && !cmd_valid) begin
      tracking <= 1'b0;
    end
  end

  // ==========================================================
  // reply generation; command replies win, the event waits a cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reply_valid <= 1'b0;
      reply <= '0;
    end else begin
      reply_valid <= 1'b0;
      reply.host <= cmd_pkg::REPLY_ADDR;
      reply.module_id <= cmd_pkg::MODULE_ADDR;
      if (frame_ok && direct_mode && !is_move) begin
        reply_valid <= 1'b1;
        reply.opcode <= cmd.opcode;
        reply.status <= cmd_pkg::ST_OK;
        reply.value <= '0;
        if (is_custom) begin
          reply.value <= custom_value;
        end
        if (is_reach) begin
          reply.value <= {24'h000000, cmd.value[7:0]};
        end
      end else if (reached && !cmd_valid) begin
        reply_valid <= 1'b1;
        reply.opcode <= cmd_pkg::OP_REACH_REQ;
        reply.status <= cmd_pkg::ST_REACHED;
        reply.value <= {24'h000000, mask};
      end
    end
  end

  logic [7:0] out_sum;
  assign out_sum = reply_part[SUM_BYTES];
  // sum is registered a cycle behind the frame to keep the adder chain off the reply path;
  // a receiver takes the checksum one cycle after reply_valid
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reply_sum <= '0;
    end else begin
      reply_sum <= out_sum;
    end
  end
endmodule : vector_return_and_reach_event_cmds
`default_nettype wire

// file: rtl/vector_table.sv
// vector table: handler entry addresses with registered read data
`timescale 1ns/1ps
`default_nettype none
module vector_table #(
  parameter int unsigned AW = cmd_pkg::VEC_AW,
  parameter int unsigned DW = cmd_pkg::PROG_AW
) (
  // clock
  input  wire logic          mclk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];

  // a later write simply replaces the old entry
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : vector_table
`default_nettype wire

// file: test/host_frame_model.sv
// host model: sends whole command frames, junk on the bus between them
`timescale 1ns/1ps
`default_nettype none
module host_frame_model (
  // clock and frame out
  input  wire logic                mclk,
  output var  logic                cmd_valid,
  output var  cmd_pkg::cmd_frame_s cmd,
  output var  logic [7:0]          cmd_sum
);
  // ==========================================================
  // framing
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    cmd_sum = 8'h00;
  end
  function automatic logic [7:0] s8(input logic [63:0] f);
    s8 = 8'h00;
    for (int i = 0; i < 8; i++) s8 += f[8*i+:8];
  endfunction : s8
  // bad flips the sum, so the device has to drop the frame
  task automatic send(input logic [7:0] op, ty, input logic [31:0] v, input logic bad);
    logic [63:0] f;
    f = {cmd_pkg::MODULE_ADDR, op, ty, 8'h00, v};
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd <= f;
    cmd_sum <= s8(f) ^ {8{bad}};
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd <= ~f;
    cmd_sum <= ~cmd_sum;
  endtask : send
endmodule : host_frame_model
`default_nettype wire

// file: test/reach_event_monitor.sv
// checker: reply content and timing at the interpreter ports
`timescale 1ns/1ps
`default_nettype none
module reach_event_monitor (
  // clock, reset and command side
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire logic                  cmd_valid,
  input wire cmd_pkg::cmd_frame_s   cmd,
  input wire logic [7:0]            cmd_sum,
  input wire logic                  direct_mode,
  input wire logic [31:0]           actual_pos,
  input wire logic [31:0]           target_pos,
  input wire logic [31:0]           custom_value,
  // reply and flow side
  input wire logic                  reply_valid,
  input wire cmd_pkg::reply_frame_s reply,
  input wire logic [7:0]            reply_sum,
  input wire logic                  ctx_restore,
  input wire logic                  in_handler,
  input wire logic                  custom_strobe
);
  // ==========================================================
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  function automatic logic [7:0] s8(input logic [63:0] f);
    s8 = 8'h00;
    for (int i = 0; i < 8; i++) s8 += f[8*i+:8];
  endfunction : s8
  logic ok;
  assign ok = cmd_valid && cmd.addr == cmd_pkg::MODULE_ADDR && cmd_sum == s8(cmd);
  chk_sum_late: assert property (
    reply_valid |=> reply_sum == s8($past(reply))) else $error("reply sum wrong");
  chk_bad_drop: assert property (
    cmd_valid && !ok |=> !reply_valid) else $error("bad frame answered");
  chk_reach_ack: assert property (
    ok && direct_mode && cmd.opcode == cmd_pkg::OP_REACH_REQ |=> reply_valid
    && reply == {16'h0201, 16'h648a, 24'h0, $past(cmd.value[7:0])}) else $error("ack frame");
  chk_ret_direct: assert property (
    ok && direct_mode && cmd.opcode == cmd_pkg::OP_RET_HANDLER |=> reply_valid
    && reply.status == cmd_pkg::ST_OK && !ctx_restore) else $error("direct return");
  chk_ret_resume: assert property (
    ok && !direct_mode && cmd.opcode == cmd_pkg::OP_RET_HANDLER && in_handler
    |=> ctx_restore && !in_handler) else $error("return did not resume");
  chk_custom_reply: assert property (
    ok && direct_mode && cmd.opcode inside {[8'h40:8'h47]} |=> reply_valid && custom_strobe
    && reply.status == 8'h64 && reply.value == $past(custom_value)) else $error("custom");
  chk_event_frame: assert property (
    reply_valid && reply.status == 8'h80 |-> reply.opcode == 8'h8a
    && reply.host == 8'h02 && reply.module_id == 8'h01
    && reply.value[31:8] == 24'h0) else $error("event frame");
  chk_event_cause: assert property (
    reply_valid && reply.status == 8'h80 |-> $past(actual_pos) == $past(target_pos)
    && !$past(cmd_valid)) else $error("event without arrival");
endmodule : reach_event_monitor
`default_nettype wire

// file: test/vector_return_and_reach_event_cmds_tb_top.sv
// testbench: interpreter with host model and bound checker
`timescale 1ns/1ps
`default_nettype none
module vector_return_and_reach_event_cmds_tb_top;
  // ==========================================================
  // bench
  logic mclk = 1'b0, reset = 1'b1, direct_mode = 1'b1, irq_enter = 1'b0;
  logic cmd_valid, reply_valid, ctx_restore, in_handler, custom_strobe;
  logic [7:0] cmd_sum, reply_sum, nn, vec_rd_num = 8'h00;
  logic [15:0] vec_rd_addr, ad;
  logic [31:0] actual_pos = '0, target_pos = '0, custom_value = '0, vv;
  cmd_pkg::cmd_frame_s cmd, custom_cmd;
  cmd_pkg::reply_frame_s reply;
  cmd_pkg::context_s live_ctx = '0, restored_ctx, cx;
  int bad_count = 0, check_count = 0, cyc = 0;
  always #25 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 3000) begin
    bad_count++;
    report_and_stop();
  end
  vector_return_and_reach_event_cmds dut_u (.mclk, .reset, .cmd_valid, .cmd, .cmd_sum,
    .direct_mode, .irq_enter, .live_ctx, .vec_rd_num, .actual_pos, .target_pos,
    .custom_value, .reply_valid, .reply, .reply_sum, .ctx_restore, .restored_ctx,
    .in_handler, .vec_rd_addr, .custom_strobe, .custom_cmd);
  host_frame_model host_u (.mclk, .cmd_valid, .cmd, .cmd_sum);
  task automatic cmp(input logic [87:0] got, exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // bounded wait, so a missing reply cannot pass on a stale frame
  task automatic expect_reply(input logic [7:0] st, op, input logic [31:0] v);
    int n = 0;
    #1;
    while (reply_valid !== 1'b1 && n++ < 8) @(posedge mclk) #1;
    cmp(reply_valid, 1'b1);
    cmp(reply, {cmd_pkg::REPLY_ADDR, cmd_pkg::MODULE_ADDR, st, op, v});
    @(posedge mclk) #1;
    cmp(reply_sum, host_u.s8(reply));
  endtask : expect_reply
  task automatic expect_quiet(input int n);
    repeat (n) begin
      #1 cmp(reply_valid, 1'b0);
      @(posedge mclk);
    end
  endtask : expect_quiet
  task automatic move_and_reach(input logic hit);
    @(posedge mclk) target_pos <= actual_pos ^ ($urandom | 32'h1);
    host_u.send(cmd_pkg::OP_MOVE_POS, 8'h00, $urandom, 1'b0);
    expect_quiet(2);
    @(posedge mclk) actual_pos <= target_pos;
    if (hit) expect_reply(cmd_pkg::ST_REACHED, cmd_pkg::OP_REACH_REQ, 32'h1);
    else expect_quiet(6);
  endtask : move_and_reach
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(25));
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    host_u.send(cmd_pkg::OP_REACH_REQ, 8'h01, 32'h1, 1'b1);
    expect_quiet(3);
    for (int t = 0; t < 2; t++) begin
      host_u.send(cmd_pkg::OP_REACH_REQ, 8'(t), 32'h1, 1'b0);
      expect_reply(cmd_pkg::ST_OK, cmd_pkg::OP_REACH_REQ, 32'h1);
      move_and_reach(1'b1);
      move_and_reach(t == 1);
    end
    for (int op = 8'h40; op <= 8'h47; op++) begin
      nn = 8'($urandom);
      vv = $urandom;
      @(posedge mclk) custom_value <= $urandom;
      host_u.send(8'(op), nn, vv, 1'b0);
      #1 cmp(custom_cmd, {cmd_pkg::MODULE_ADDR, 8'(op), nn, 8'h00, vv});
      expect_reply(cmd_pkg::ST_OK, 8'(op), custom_value);
    end
    host_u.send(cmd_pkg::OP_RET_HANDLER, 8'hff, 32'h0, 1'b0);
    expect_reply(cmd_pkg::ST_OK, cmd_pkg::OP_RET_HANDLER, 32'h0);
    @(posedge mclk) direct_mode <= 1'b0;
    nn = 8'($urandom);
    repeat (2) begin
      ad = 16'($urandom);
      host_u.send(cmd_pkg::OP_DEF_VECTOR, nn, {16'h0, ad}, 1'b0);
      @(posedge mclk) vec_rd_num <= nn;
      repeat (3) @(posedge mclk);
      #1 cmp(vec_rd_addr, ad);
    end
    cx = 88'({$urandom, $urandom, $urandom});
    @(posedge mclk) live_ctx <= cx;
    irq_enter <= 1'b1;
    @(posedge mclk) irq_enter <= 1'b0;
    live_ctx <= ~cx;
    host_u.send(cmd_pkg::OP_RET_HANDLER, 8'hff, 32'h0, 1'b0);
    #1 cmp(ctx_restore, 1'b1);
    cmp(restored_ctx, cx);
    report_and_stop();
  end
endmodule : vector_return_and_reach_event_cmds_tb_top
bind vector_return_and_reach_event_cmds reach_event_monitor mon_u (.mclk, .reset, .cmd_valid,
  .cmd, .cmd_sum, .direct_mode, .actual_pos, .target_pos, .custom_value, .reply_valid,
  .reply, .reply_sum, .ctx_restore, .in_handler, .custom_strobe);
`default_nettype wire
